/* File: design/burst_fifo.sv */
// Nibble FIFO with valid/ready on both sides and a flush
`default_nettype none
module burst_fifo #(
  parameter int W     = 4,
  parameter int DEPTH = 16
) (
  // Clock, reset and flush
  input  wire logic   clk_i,
  input  wire logic   arst_n_i,
  input  wire logic   flush_i,
  // Streams
  nib_stream_if.snk   in_s,
  nib_stream_if.src   out_s
);
  localparam int PW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [PW:0]   count, next_count;
  logic          push, pop;

  // Honest full and empty from the count
  assign in_s.ready  = (count != (PW+1)'(DEPTH));
  assign out_s.valid = (count != '0);
  assign out_s.data  = mem[rd_ptr];
  assign push = in_s.valid && in_s.ready;
  assign pop  = out_s.valid && out_s.ready;

  // Pointer and count updates, flush wins
  always_comb begin
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count  = count + (PW+1)'(push) - (PW+1)'(pop);
    if (flush_i) begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_count  = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_s.data;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end
endmodule
`default_nettype wire

/* File: design/pattern_burst_seq.sv */
// Infrared pattern burst sequencer with register port
`default_nettype none
module pattern_burst_seq #(
  parameter int FIFO_DEPTH = 16,
  parameter int RAM_AW     = 7
) (
  // Clock and reset
  input  wire logic       MCLK_I,
  input  wire logic       ARST_N_I,
  // Register port
  input  wire logic [7:0] REG_ADDR_I,
  input  wire logic       REG_WR_I,
  input  wire logic [7:0] REG_WDATA_I,
  input  wire logic       REG_RD_I,
  output var  logic [7:0] REG_RDATA_O,
  // LED and status
  output var  logic       LED_DRIVE_OUTPUT_O,
  output wire logic       BURST_BUSY_O,
  output wire logic       IRQ_O
);
  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  logic [7:0] packet_loop_count, packet_off_time, symbol_nibble_length;
  logic [7:0] symbol_loop_count, symbol_off_time, pat_addr;
  logic [burst_pkg::BT_W-1:0] bit_time_value;
  logic [burst_pkg::QZ_W-1:0] quiet_zone_length;
  logic burst_irq_enable, burst_done_flag;
  logic [7:0] next_plc, next_pot, next_snl, next_slc, next_sot, next_pad;
  logic [burst_pkg::BT_W-1:0] next_btv;
  logic [burst_pkg::QZ_W-1:0] next_qz;
  logic next_irq_en, next_done;
  logic [7:0] next_rdata;
  logic start, clear_wr, done_set, ram_we;
  logic busy;

  // Write strobes decoded once
  assign start    = REG_WR_I && (REG_ADDR_I == burst_pkg::OFS_SYM_LEN);
  assign clear_wr = REG_WR_I && (REG_ADDR_I == burst_pkg::OFS_FLAG_CLEAR);
  assign ram_we   = REG_WR_I && (REG_ADDR_I == burst_pkg::OFS_PAT_DATA);

  // Register writes
  always_comb begin
    next_plc    = packet_loop_count;
    next_pot    = packet_off_time;
    next_snl    = symbol_nibble_length;
    next_slc    = symbol_loop_count;
    next_sot    = symbol_off_time;
    next_btv    = bit_time_value;
    next_qz     = quiet_zone_length;
    next_irq_en = burst_irq_enable;
    next_pad    = ram_we ? pat_addr + 8'h01 : pat_addr;
    if (REG_WR_I) begin
      case (REG_ADDR_I)
        burst_pkg::OFS_PKT_LOOPS: next_plc = REG_WDATA_I;
        burst_pkg::OFS_PKT_OFF:   next_pot = REG_WDATA_I;
        burst_pkg::OFS_SYM_LOOPS: next_slc = REG_WDATA_I;
        burst_pkg::OFS_SYM_OFF:   next_sot = REG_WDATA_I;
        burst_pkg::OFS_PAT_ADDR:  next_pad = REG_WDATA_I;
        burst_pkg::OFS_BIT_TIME:  next_btv = REG_WDATA_I[burst_pkg::BT_W-1:0];
        burst_pkg::OFS_QZ_CFG: begin
          next_qz     = REG_WDATA_I[burst_pkg::QZ_W-1:0];
          next_irq_en = REG_WDATA_I[burst_pkg::IRQ_EN_BIT];
        end
        burst_pkg::OFS_SYM_LEN:   next_snl = REG_WDATA_I;
        default: ;
      endcase
    end
  end

  assign next_done = done_set || (burst_done_flag && !clear_wr);

  // Read mux, unmapped addresses read zero
  always_comb begin
    next_rdata = REG_RDATA_O;
    if (REG_RD_I) begin
      case (REG_ADDR_I)
        burst_pkg::OFS_PKT_LOOPS: next_rdata = packet_loop_count;
        burst_pkg::OFS_PKT_OFF:   next_rdata = packet_off_time;
        burst_pkg::OFS_SYM_LOOPS: next_rdata = symbol_loop_count;
        burst_pkg::OFS_SYM_OFF:   next_rdata = symbol_off_time;
        burst_pkg::OFS_PAT_ADDR:  next_rdata = pat_addr;
        burst_pkg::OFS_BIT_TIME:  next_rdata = 8'(bit_time_value);
        burst_pkg::OFS_SYM_LEN:   next_rdata = symbol_nibble_length;
        burst_pkg::OFS_QZ_CFG: begin
          next_rdata = 8'(quiet_zone_length);
          next_rdata[burst_pkg::IRQ_EN_BIT] = burst_irq_enable;
        end
        burst_pkg::OFS_BURST_STATUS,
        burst_pkg::OFS_GEN_STATUS:
          next_rdata = {6'h00, burst_done_flag, busy};
        default:                  next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      packet_loop_count    <= burst_pkg::RST_CFG;
      packet_off_time      <= burst_pkg::RST_CFG;
      symbol_nibble_length <= burst_pkg::RST_CFG;
      symbol_loop_count    <= burst_pkg::RST_CFG;
      symbol_off_time      <= burst_pkg::RST_CFG;
      pat_addr             <= burst_pkg::RST_CFG;
      bit_time_value       <= '0;
      quiet_zone_length    <= '0;
      burst_irq_enable     <= 1'b0;
      burst_done_flag      <= 1'b0;
      REG_RDATA_O          <= 8'h00;
    end else begin
      packet_loop_count    <= next_plc;
      packet_off_time      <= next_pot;
      symbol_nibble_length <= next_snl;
      symbol_loop_count    <= next_slc;
      symbol_off_time      <= next_sot;
      pat_addr             <= next_pad;
      bit_time_value       <= next_btv;
      quiet_zone_length    <= next_qz;
      burst_irq_enable     <= next_irq_en;
      burst_done_flag      <= next_done;
      REG_RDATA_O          <= next_rdata;
    end
  end

  assign IRQ_O = burst_done_flag && burst_irq_enable;

  // ----------------------------------------
  // Pattern fetch into the FIFO
  // ----------------------------------------
  nib_stream_if #(.W(burst_pkg::NIB_BITS)) fill_s ();
  nib_stream_if #(.W(burst_pkg::NIB_BITS)) drain_s ();
  logic [7:0] ram_rdata, fetch_addr, next_fetch_addr;
  logic fetch_on, next_fetch_on, pending, next_pending, sym_go;

  pattern_ram #(.AW(RAM_AW), .DW(8)) u_ram (
    .clk_i    (MCLK_I),
    .arst_n_i (ARST_N_I),
    .we_i     (ram_we),
    .waddr_i  (pat_addr[RAM_AW-1:0]),
    .wdata_i  (REG_WDATA_I),
    .re_i     (fetch_on && !pending),
    .raddr_i  (fetch_addr[RAM_AW:1]),
    .rdata_o  (ram_rdata)
  );

  assign fill_s.valid = pending;
  assign fill_s.data  = fetch_addr[0] ? ram_rdata[7:4] : ram_rdata[3:0];

  // Fetcher stalls on a full FIFO
  always_comb begin
    next_fetch_on   = fetch_on;
    next_fetch_addr = fetch_addr;
    next_pending    = pending;
    if (fetch_on && !pending) begin
      next_pending = 1'b1;
    end
    if (pending && fill_s.ready) begin
      next_pending = 1'b0;
      if (fetch_addr == symbol_nibble_length) begin
        next_fetch_on = 1'b0;
      end else begin
        next_fetch_addr = fetch_addr + 8'h01;
      end
    end
    if (sym_go) begin
      next_fetch_on   = 1'b1;
      next_fetch_addr = 8'h00;
      next_pending    = 1'b0;
    end
  end

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      fetch_on   <= 1'b0;
      fetch_addr <= 8'h00;
      pending    <= 1'b0;
    end else begin
      fetch_on   <= next_fetch_on;
      fetch_addr <= next_fetch_addr;
      pending    <= next_pending;
    end
  end

  // Stale nibbles dropped on every restart
  burst_fifo #(.W(burst_pkg::NIB_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i    (MCLK_I),
    .arst_n_i (ARST_N_I),
    .flush_i  (start),
    .in_s     (fill_s),
    .out_s    (drain_s)
  );

  // ----------------------------------------
  // Bit-time tick and sequencer
  // ----------------------------------------
  burst_pkg::seq_state_t state, next_state;
  logic [10:0] tick_cnt, next_tick_cnt, period, phase, next_phase;
  logic [10:0] qz_len, soff_len, poff_len;
  logic [7:0]  pkt_cnt, next_pkt, sym_cnt, next_sym, nib_cnt, next_nib;
  logic [3:0]  shift, next_shift;
  logic [1:0]  bit_idx, next_bit;
  logic        loaded, next_loaded, tick, tick_clr, next_led;
  logic        do_begin, do_after;

  assign period = 11'((11'(bit_time_value) + 11'h001) * 11'(burst_pkg::BIT_BASE_CYC));
  assign tick   = (tick_cnt == period - 11'h001);
  assign next_tick_cnt = (tick_clr || tick) ? 11'h000 : tick_cnt + 11'h001;
  assign qz_len   = 11'((11'h002 << quiet_zone_length) + 11'h001);
  assign soff_len = 11'((11'(symbol_off_time) << 1) + 11'h001);
  assign poff_len = 11'((11'(packet_off_time) + 11'h001) << 2);
  assign busy = (state != burst_pkg::S_IDLE);
  assign BURST_BUSY_O = busy;
  assign drain_s.ready = (state == burst_pkg::S_PAT) && !start
                         && (!loaded || (tick && bit_idx == 2'h3
                             && nib_cnt != symbol_nibble_length));

  // Phase sequencing, counted in bit-times
  always_comb begin
    next_state  = state;
    next_phase  = phase;
    next_pkt    = pkt_cnt;
    next_sym    = sym_cnt;
    next_nib    = nib_cnt;
    next_shift  = shift;
    next_bit    = bit_idx;
    next_loaded = loaded;
    tick_clr    = 1'b0;
    sym_go      = 1'b0;
    done_set    = 1'b0;
    do_begin    = 1'b0;
    do_after    = 1'b0;
    case (state)
      burst_pkg::S_IDLE: ;
      burst_pkg::S_QZ_PRE: begin
        if (tick) begin
          if (phase == 11'h000) begin
            next_state = burst_pkg::S_PAT;
          end else begin
            next_phase = phase - 11'h001;
          end
        end
      end
      burst_pkg::S_PAT: begin
        if (!loaded) begin
          // Bit-time starts once data is there
          tick_clr = 1'b1;
          if (drain_s.valid) begin
            next_shift  = drain_s.data;
            next_bit    = 2'h0;
            next_loaded = 1'b1;
          end
        end else if (tick) begin
          if (bit_idx != 2'h3) begin
            next_shift = shift >> 1;
            next_bit   = bit_idx + 2'h1;
          end else if (nib_cnt == symbol_nibble_length) begin
            next_loaded = 1'b0;
            if (quiet_zone_length != '0) begin
              next_state = burst_pkg::S_QZ_POST;
              next_phase = qz_len - 11'h001;
            end else begin
              do_after = 1'b1;
            end
          end else begin
            next_nib    = nib_cnt + 8'h01;
            next_shift  = drain_s.data;
            next_bit    = 2'h0;
            next_loaded = drain_s.valid;
          end
        end
      end
      burst_pkg::S_QZ_POST: begin
        if (tick) begin
          if (phase == 11'h000) begin
            do_after = 1'b1;
          end else begin
            next_phase = phase - 11'h001;
          end
        end
      end
      burst_pkg::S_SYM_OFF, burst_pkg::S_PKT_OFF: begin
        if (tick) begin
          if (phase == 11'h000) begin
            do_begin = 1'b1;
          end else begin
            next_phase = phase - 11'h001;
          end
        end
      end
      default: next_state = burst_pkg::S_IDLE;
    endcase
    if (do_after) begin
      if (sym_cnt != symbol_loop_count) begin
        next_state = burst_pkg::S_SYM_OFF;
        next_phase = soff_len - 11'h001;
        next_sym   = sym_cnt + 8'h01;
      end else if (pkt_cnt != packet_loop_count) begin
        next_state = burst_pkg::S_PKT_OFF;
        next_phase = poff_len - 11'h001;
        next_pkt   = pkt_cnt + 8'h01;
        next_sym   = 8'h00;
      end else begin
        next_state = burst_pkg::S_IDLE;
        done_set   = 1'b1;
      end
    end
    // restart from the very first symbol
    if (start) begin
      next_pkt = 8'h00;
      next_sym = 8'h00;
      do_begin = 1'b1;
    end
    if (do_begin) begin
      tick_clr    = 1'b1;
      sym_go      = 1'b1;
      next_nib    = 8'h00;
      next_loaded = 1'b0;
      next_phase  = qz_len - 11'h001;
      next_state  = (quiet_zone_length != '0) ? burst_pkg::S_QZ_PRE
                                              : burst_pkg::S_PAT;
    end
    next_led = (next_state == burst_pkg::S_PAT) && next_loaded && next_shift[0];
  end

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      state              <= burst_pkg::S_IDLE;
      tick_cnt           <= 11'h000;
      phase              <= 11'h000;
      pkt_cnt            <= 8'h00;
      sym_cnt            <= 8'h00;
      nib_cnt            <= 8'h00;
      shift              <= 4'h0;
      bit_idx            <= 2'h0;
      loaded             <= 1'b0;
      LED_DRIVE_OUTPUT_O <= 1'b0;
    end else begin
      state              <= next_state;
      tick_cnt           <= next_tick_cnt;
      phase              <= next_phase;
      pkt_cnt            <= next_pkt;
      sym_cnt            <= next_sym;
      nib_cnt            <= next_nib;
      shift              <= next_shift;
      bit_idx            <= next_bit;
      loaded             <= next_loaded;
      LED_DRIVE_OUTPUT_O <= next_led;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!ARST_N_I);

  sequence s_start;
    REG_WR_I && (REG_ADDR_I == burst_pkg::OFS_SYM_LEN);
  endsequence
  sequence s_stat_rd;
    REG_RD_I && (REG_ADDR_I == burst_pkg::OFS_BURST_STATUS);
  endsequence

  a_start_busy: assert property (s_start |=> busy)
    else $error("length write did not start a burst");
  a_restart_first: assert property (s_start |=>
    pkt_cnt == 8'h00 && sym_cnt == 8'h00 && !loaded)
    else $error("restart did not return to first symbol");
  a_done_busy: assert property ($fell(busy) |-> burst_done_flag)
    else $error("busy fell without done flag");
  a_done_sticky: assert property (burst_done_flag && !clear_wr |=> burst_done_flag)
    else $error("done flag lost without clear");
  a_mirror_read: assert property (
    REG_RD_I && REG_ADDR_I == burst_pkg::OFS_GEN_STATUS |=>
    REG_RDATA_O[burst_pkg::DONE_BIT] == $past(burst_done_flag))
    else $error("general status lacks done flag");
  a_status_read: assert property (s_stat_rd |=>
    REG_RDATA_O == {6'h00, $past(burst_done_flag), $past(busy)})
    else $error("status read wrong");
  a_ro_status: assert property (
    REG_WR_I && REG_ADDR_I == burst_pkg::OFS_BURST_STATUS && !busy |=> !busy)
    else $error("status write disturbed sequencer");
  a_led_in_pat: assert property (LED_DRIVE_OUTPUT_O |-> state == burst_pkg::S_PAT)
    else $error("LED lit outside pattern");
  a_tick_space: assert property (tick |=> !tick [*8])
    else $error("bit-time shorter than base period");
  a_irq_gate: assert property ($rose(burst_done_flag) && burst_irq_enable |-> IRQ_O)
    else $error("enabled interrupt not raised");
endmodule
`default_nettype wire

/* File: design/pattern_ram.sv */
// Pattern memory with registered read data
`default_nettype none
module pattern_ram #(
  parameter int AW = 7,
  parameter int DW = 8
) (
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          arst_n_i,
  // Write side
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [DW-1:0] wdata_i,
  // Read side
  input  wire logic          re_i,
  input  wire logic [AW-1:0] raddr_i,
  output var  logic [DW-1:0] rdata_o
);
  logic [DW-1:0] mem [2**AW];
  logic [DW-1:0] next_rdata;

  // Read data holds while no read is issued
  always_comb begin
    next_rdata = re_i ? mem[raddr_i] : rdata_o;
  end

  // Array carries no reset, contents are software loaded
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= next_rdata;
    end
  end
endmodule
`default_nettype wire

/* File: shared/burst_pkg.sv */
// Constants and types shared by the pattern burst sequencer
`default_nettype none
package burst_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_GEN_STATUS   = 8'h93;
  localparam logic [7:0] OFS_QZ_CFG       = 8'h9F;
  localparam logic [7:0] OFS_SYM_LOOPS    = 8'hA2;
  localparam logic [7:0] OFS_SYM_OFF      = 8'hA3;
  localparam logic [7:0] OFS_PKT_LOOPS    = 8'hA4;
  localparam logic [7:0] OFS_PKT_OFF      = 8'hA5;
  localparam logic [7:0] OFS_BIT_TIME     = 8'hA6;
  localparam logic [7:0] OFS_SYM_LEN      = 8'hA7;
  localparam logic [7:0] OFS_BURST_STATUS = 8'hA8;
  localparam logic [7:0] OFS_PAT_ADDR     = 8'hB0;
  localparam logic [7:0] OFS_PAT_DATA     = 8'hB1;
  localparam logic [7:0] OFS_FLAG_CLEAR   = 8'hE3;
  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int         BUSY_BIT   = 0;
  localparam int         DONE_BIT   = 1;
  localparam int         IRQ_EN_BIT = 5;
  localparam int         QZ_W       = 3;
  localparam int         BT_W       = 6;
  localparam logic [7:0] RST_CFG    = 8'h00;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int BIT_BASE_NS   = 270;
  localparam int BIT_BASE_CYC  = BIT_BASE_NS / CLK_PERIOD_NS;
  localparam int NIB_BITS      = 4;
  // Sequencer states
  typedef enum logic [2:0] {
    S_IDLE, S_QZ_PRE, S_PAT, S_QZ_POST, S_SYM_OFF, S_PKT_OFF
  } seq_state_t;
endpackage
`default_nettype wire

/* File: shared/nib_stream_if.sv */
// Valid/ready nibble stream between fetcher, FIFO and serialiser
`default_nettype none
interface nib_stream_if #(parameter int W = 4) ();
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

/* File: tb/led_scanner.sv */
// Scanner-side model that counts LED light time and light pulses
`default_nettype none
module led_scanner (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  // Count clear and LED
  input  wire logic        clr_i,
  input  wire logic        led_i,
  // Results
  output var  logic [15:0] on_cyc_o,
  output var  logic [15:0] rise_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic prev;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prev     <= 1'b0;
      on_cyc_o <= 16'h0000;
      rise_o   <= 16'h0000;
    end else if (clr_i) begin
      prev     <= led_i;
      on_cyc_o <= 16'h0000;
      rise_o   <= 16'h0000;
    end else begin
      prev     <= led_i;
      on_cyc_o <= on_cyc_o + {15'h0000, led_i};
      rise_o   <= rise_o + {15'h0000, led_i & ~prev};
    end
  end
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench for the pattern burst sequencer
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk = 1'b0;
  logic        arst_n = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic        wr = 1'b0;
  logic [7:0]  wdata = 8'h00;
  logic        rd = 1'b0;
  logic        clr = 1'b0;
  logic [7:0]  rdata;
  logic        led;
  logic        busy;
  logic        irq;
  logic [15:0] on_cyc;
  logic [15:0] rises;
  logic [15:0] n1;
  logic [15:0] n2;
  logic [7:0]  v;
  int          fails = 0;
  int          checks_done = 0;
  // 100 MHz clock
  always #5 mclk = ~mclk;
  pattern_burst_seq pattern_burst_seq_i (.MCLK_I(mclk), .ARST_N_I(arst_n),
    .REG_ADDR_I(addr), .REG_WR_I(wr), .REG_WDATA_I(wdata), .REG_RD_I(rd),
    .REG_RDATA_O(rdata), .LED_DRIVE_OUTPUT_O(led), .BURST_BUSY_O(busy), .IRQ_O(irq));
  led_scanner led_scanner_i (.clk_i(mclk), .arst_n_i(arst_n), .clr_i(clr), .led_i(led),
    .on_cyc_o(on_cyc), .rise_o(rises));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One-cycle strobes, launched at the falling edge
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge mclk);
    wr = 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(negedge mclk);
    addr = a;
    rd = 1'b1;
    @(negedge mclk);
    rd = 1'b0;
    @(negedge mclk);
    chk({8'h00, rdata & m}, {8'h00, e});
  endtask
  // Loads one pattern byte and starts; scanner counts cleared across the start
  task automatic run(input logic [7:0] pat, input logic [7:0] len, input logic [7:0] pl,
                     input logic [7:0] sl);
    wr_reg(burst_pkg::OFS_PAT_ADDR, 8'h00);
    wr_reg(burst_pkg::OFS_PAT_DATA, pat);
    wr_reg(burst_pkg::OFS_PKT_LOOPS, pl);
    wr_reg(burst_pkg::OFS_SYM_LOOPS, sl);
    clr = 1'b1;
    wr_reg(burst_pkg::OFS_SYM_LEN, len);
    clr = 1'b0;
    @(negedge mclk);
    chk({15'h0000, busy}, 16'h0001);
  endtask
  // Bounded wait; returns busy length so gaps show as differences
  task automatic wait_idle(output logic [15:0] n);
    n = 16'h0000;
    while (busy !== 1'b0 && n < 16'h9000) begin
      @(negedge mclk);
      n++;
    end
    chk({15'h0000, busy}, 16'h0000);
  endtask
  task automatic t_regs;
    rd_chk(burst_pkg::OFS_SYM_OFF, 8'hFF, 8'h00);
    wr_reg(burst_pkg::OFS_PKT_OFF, 8'h5A);
    rd_chk(burst_pkg::OFS_PKT_OFF, 8'hFF, 8'h5A);
    // Reserved bits kept at zero, as software must
    wr_reg(burst_pkg::OFS_BIT_TIME, 8'h3F);
    rd_chk(burst_pkg::OFS_BIT_TIME, 8'hFF, 8'h3F);
    wr_reg(burst_pkg::OFS_BURST_STATUS, 8'hFF);
    rd_chk(burst_pkg::OFS_BURST_STATUS, 8'hFF, 8'h00);
    rd_chk(8'h00, 8'hFF, 8'h00);
    wr_reg(burst_pkg::OFS_PKT_OFF, 8'h00);
    wr_reg(burst_pkg::OFS_BIT_TIME, 8'h00);
    $display("test regs done");
  endtask
  task automatic t_single;
    wr_reg(burst_pkg::OFS_QZ_CFG, 8'h20);
    run(8'h05, 8'h00, 8'h00, 8'h00);
    wait_idle(n1);
    chk(on_cyc, 16'd54);
    chk(rises, 16'd2);
    rd_chk(burst_pkg::OFS_BURST_STATUS, 8'hFF, 8'h02);
    rd_chk(burst_pkg::OFS_GEN_STATUS, 8'h03, 8'h02);
    chk({15'h0000, irq}, 16'h0001);
    wr_reg(burst_pkg::OFS_FLAG_CLEAR, 8'h00);
    rd_chk(burst_pkg::OFS_BURST_STATUS, 8'hFF, 8'h00);
    wr_reg(burst_pkg::OFS_QZ_CFG, 8'h01);
    run(8'h05, 8'h00, 8'h00, 8'h00);
    wait_idle(n2);
    // Ten quiet bit-times; two fetch stall cycles hide under the leading zone
    chk(n2 - n1, 16'(10 * burst_pkg::BIT_BASE_CYC - 2));
    chk({15'h0000, irq}, 16'h0000);
    wr_reg(burst_pkg::OFS_QZ_CFG, 8'h00);
    wr_reg(burst_pkg::OFS_BIT_TIME, 8'h01);
    run(8'h05, 8'h00, 8'h00, 8'h00);
    wait_idle(n2);
    chk(on_cyc, 16'd108);
    wr_reg(burst_pkg::OFS_BIT_TIME, 8'h00);
    run(8'hF1, 8'h01, 8'h00, 8'h00);
    wait_idle(n2);
    chk(on_cyc, 16'd135);
    chk(rises, 16'd2);
    $display("test single done");
  endtask
  task automatic t_loops;
    run(8'h05, 8'h00, 8'h01, 8'h01);
    wait_idle(n1);
    chk(rises, 16'd8);
    chk(on_cyc, 16'd216);
    wr_reg(burst_pkg::OFS_SYM_OFF, 8'h03);
    run(8'h05, 8'h00, 8'h01, 8'h01);
    wait_idle(n2);
    chk(n2 - n1, 16'd324);
    wr_reg(burst_pkg::OFS_SYM_OFF, 8'h00);
    wr_reg(burst_pkg::OFS_PKT_OFF, 8'h02);
    run(8'h05, 8'h00, 8'h01, 8'h01);
    wait_idle(n2);
    chk(n2 - n1, 16'd216);
    wr_reg(burst_pkg::OFS_PKT_OFF, 8'h00);
    $display("test loops done");
  endtask
  task automatic t_restart;
    run(8'h05, 8'h00, 8'h00, 8'h00);
    wait_idle(n1);
    run(8'h05, 8'h00, 8'h0F, 8'h00);
    repeat (100) @(negedge mclk);
    wr_reg(burst_pkg::OFS_PKT_LOOPS, 8'h00);
    clr = 1'b1;
    wr_reg(burst_pkg::OFS_SYM_LEN, 8'h00);
    clr = 1'b0;
    @(negedge mclk);
    wait_idle(n2);
    chk(n2, n1);
    chk(rises, 16'd2);
    $display("test restart done");
  endtask
  task automatic test_done;
    $display("Checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Watchdog well beyond the few thousand cycles the tests need
  initial begin
    #400000;
    fails++;
    test_done();
  end
  initial begin
    repeat (2) @(negedge mclk);
    arst_n = 1'b1;
    t_regs();
    t_single();
    t_loops();
    t_restart();
    test_done();
  end
endmodule
`default_nettype wire
